// ---- bench/port_clock_sva.sv ----
// Purpose: Port-level assertions for port_clock_control.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound into every instance of the design.
`timescale 1ns/1ps
module port_clock_sva
    import port_clock_gate_pkg::*;
#(
    parameter int PORTS = 8
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic port_req_valid,
    input wire logic [PORT_INDEX_WIDTH-1:0] port_req_index,
    input wire logic port_req_grant,
    input wire logic port_req_fault,
    input wire logic [PORTS-1:0] port_clk,
    input wire logic [PORTS-1:0] port_clock_on,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_taken;
        hsel && htrans == HTRANS_NONSEQ && hready;
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_one_wait: assert property (s_taken |=> s_wait) else $error("wait state wrong");
    a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("response not okay");
    a_rsvd_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper bits nonzero");
    a_fault_off: assert property (port_req_valid && !port_clock_on[port_req_index]
        |=> port_req_fault && !port_req_grant) else $error("no fault on gated port");
    a_grant_on: assert property (port_req_valid && port_clock_on[port_req_index]
        |=> port_req_grant && !port_req_fault) else $error("no grant on clocked port");
    a_quiet_idle: assert property (!port_req_valid |=> !port_req_grant && !port_req_fault)
        else $error("answer without request");
    a_reset_clear: assert property ($fell(reset) |-> port_clock_on == '0 && !irq)
        else $error("not cleared by reset");
    // Sampled at the end of each high phase: a gate that moved while high would differ from the older enable
    a_clk_low: assert property (@(negedge ref_clk) port_clk == $past(port_clock_on))
        else $error("gated clock pulse cut short");
    // A register write and a sleep level change both show two edges after they are first sampled
    a_gate_cause: assert property (!$stable(port_clock_on) |-> $past(reset) || !$past(hreadyout, 2)
        || $past(sleep_req, 2) != $past(sleep_req, 3) || $past(deep_sleep_req, 2) != $past(deep_sleep_req, 3))
        else $error("enable moved without cause");
endmodule : port_clock_sva
bind port_clock_control port_clock_sva #(.PORTS(PORTS)) sva_u
(
    .ref_clk(ref_clk),
    .reset(reset),
    .hsel(hsel),
    .htrans(htrans),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req),
    .port_req_valid(port_req_valid),
    .port_req_index(port_req_index),
    .port_req_grant(port_req_grant),
    .port_req_fault(port_req_fault),
    .port_clk(port_clk),
    .port_clock_on(port_clock_on),
    .irq(irq)
);

// ---- bench/port_model.sv ----
// Purpose: Far-side model of the eight gated port modules.
// Assumes: Each port runs only on its own gated clock.
// Notes: seen is sticky per port until clear; it shows which ports got clock edges.
`timescale 1ns/1ps
module port_model
(
    input wire logic clear,
    input wire logic [7:0] port_clk,
    output logic [7:0] seen
);
    for (genvar g = 0; g < 8; g++)
    begin : g_port
        // A port with no clock edge cannot mark itself, as a real gated module
        always @(posedge port_clk[g] or posedge clear)
        begin
            if (clear)
                seen[g] <= 1'b0;
            else
                seen[g] <= 1'b1;
        end
    end
endmodule : port_model

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for port_clock_control.
// Assumes: One AHB-Lite slave, hready tied to hreadyout.
// Notes: Rows cover run-register writes; faults, interrupt, sleep and reset follow.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import port_clock_gate_pkg::*;
    logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, sleep_req = 0, deep_sleep_req = 0;
    logic port_req_valid = 0, clear = 0, hready, hreadyout, hresp, port_req_grant, port_req_fault, irq;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = HTRANS_IDLE;
    logic [2:0] hsize = 3'h2, port_req_index = '0;
    logic [7:0] port_clk, port_clock_on, seen;
    logic [31:0] wv [5] = '{32'hFFFFFFFF, 32'h00000001, 32'h00000080, 32'hA5A5A55A, 32'h00000004};
    logic [31:0] ev [5] = '{32'h000000FF, 32'h00000001, 32'h00000080, 32'h0000005A, 32'h00000004};
    int n_mismatch = 0, total_checks = 0, cycles = 0;
    assign hready = hreadyout;
    always #2 ref_clk = ~ref_clk;
    port_clock_control dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .port_req_valid(port_req_valid), .port_req_index(port_req_index), .port_req_grant(port_req_grant),
        .port_req_fault(port_req_fault), .port_clk(port_clk), .port_clock_on(port_clock_on), .irq(irq));
    port_model far_u (.clear(clear), .port_clk(port_clk), .seen(seen));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Caller enters just after a rising edge; the answer is awaited, never counted
    task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd,
        input logic [31:0] base = SYSCTL_BASE);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= base + 32'(off);
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        bus(0, RUN_GATE_OFFSET, 0);
        `CHK(rd, 32'h0)
        `CHK(port_clock_on, 8'h00)
        for (int i = 0; i < 5; i++)
        begin
            bus(1, RUN_GATE_OFFSET, wv[i]);
            bus(0, RUN_GATE_OFFSET, 0);
            `CHK(rd, ev[i])
            clear <= 1'b1;
            @(posedge ref_clk);
            clear <= 1'b0;
            repeat (4) @(posedge ref_clk);
            `CHK(port_clock_on, ev[i][7:0])
            `CHK(seen, ev[i][7:0])
            $display("row %0d done", i);
        end
        bus(0, RUN_GATE_OFFSET, 0, 32'h400FF000);
        `CHK(rd, 32'h0)
        bus(0, 12'h10C, 0);
        `CHK(rd, 32'h0)
        bus(0, RUN_GATE_OFFSET, 0);
        bus(1, RUN_GATE_OFFSET, rd | 32'h1);
        bus(0, RUN_GATE_OFFSET, 0);
        `CHK(rd, 32'h5)
        $display("decode done");
        // Ports A and C were enabled above, before any access is aimed at them
        for (int i = 0; i <= 8; i++)
        begin
            @(posedge ref_clk);
            port_req_valid <= (i < 8);
            port_req_index <= 3'(i);
            #1;
            if (i > 0)
            begin
                `CHK(port_req_fault, (i != 1 && i != 3))
                `CHK(port_req_grant, (i == 1 || i == 3))
            end
        end
        bus(0, FAULT_STATUS_OFFSET, 0);
        `CHK(rd, 32'hFA)
        bus(1, FAULT_MASK_OFFSET, 32'h0);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        bus(1, FAULT_MASK_OFFSET, 32'h8);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        bus(1, FAULT_STATUS_OFFSET, 32'h8);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        bus(0, FAULT_STATUS_OFFSET, 0);
        `CHK(rd, 32'hF2)
        // A fault on port B lands in the very cycle of its write-one-to-clear; the set must win
        port_req_valid <= 1'b1;
        port_req_index <= 3'h1;
        fork
            bus(1, FAULT_STATUS_OFFSET, 32'h2);
            begin
                @(posedge ref_clk);
                port_req_valid <= 1'b0;
            end
        join
        bus(0, FAULT_STATUS_OFFSET, 0);
        `CHK(rd, 32'hF2)
        $display("fault done");
        bus(1, SLEEP_GATE_OFFSET, 32'h10);
        bus(1, DEEP_GATE_OFFSET, 32'h20);
        sleep_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(port_clock_on, 8'h05)
        bus(1, CLOCK_CONFIG_OFFSET, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHK(port_clock_on, 8'h10)
        deep_sleep_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(port_clock_on, 8'h20)
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK(port_clock_on, 8'h05)
        bus(0, SLEEP_GATE_OFFSET, 0);
        `CHK(rd, 32'h10)
        bus(0, DEEP_GATE_OFFSET, 0);
        `CHK(rd, 32'h20)
        bus(0, CLOCK_CONFIG_OFFSET, 0);
        `CHK(rd, 32'h1)
        bus(1, GATE_STATE_OFFSET, 32'hFF);
        bus(0, GATE_STATE_OFFSET, 0);
        `CHK(rd, 32'h5)
        $display("sleep done");
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK(port_clock_on, 8'h00)
        bus(0, RUN_GATE_OFFSET, 0);
        `CHK(rd, 32'h0)
        $display("reset done");
        give_verdict();
    end
endmodule : tb

// ---- rtl/glitch_free_clock_gate.sv ----
// Purpose: Glitch-free gate for one port module clock.
// Assumes: enable is synchronous to the rising edge of clk_in.
// Notes: The enable is retimed on the falling edge so it only moves while clk_in is low.
`timescale 1ns/1ps
module glitch_free_clock_gate
(
    input wire logic clk_in,
    input wire logic reset,
    input wire logic enable,
    output logic clk_out
);
    logic enable_low_r;

    // Changing only in the low phase keeps every gated pulse full width
    always_ff @(negedge clk_in)
    begin
        if (reset)
            enable_low_r <= 1'b0;
        else
            enable_low_r <= enable;
    end

    assign clk_out = clk_in & enable_low_r;
endmodule : glitch_free_clock_gate

// ---- rtl/port_access_guard.sv ----
// Purpose: Checks each access aimed at a port module against that port's clock state.
// Assumes: One access request per cycle, index points at the target port.
// Notes: Answers are one-cycle pulses one clock after the request.
`timescale 1ns/1ps
module port_access_guard
#(
    parameter int PORTS = 8,
    parameter int INDEX_WIDTH = 3
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic [INDEX_WIDTH-1:0] req_index,
    input wire logic [PORTS-1:0] clock_on,
    output logic grant_r,
    output logic fault_r,
    output logic [PORTS-1:0] fault_event_r
);
    logic [PORTS-1:0] target;
    logic target_clocked;

    always_comb
    begin
        target = '0;
        target[req_index] = 1'b1;
        target_clocked = |(target & clock_on);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            grant_r <= 1'b0;
            fault_r <= 1'b0;
            fault_event_r <= '0;
        end
        else
        begin
            grant_r <= req_valid & target_clocked;
            fault_r <= req_valid & ~target_clocked;
            fault_event_r <= (req_valid & ~target_clocked) ? target : '0;
        end
    end
endmodule : port_access_guard

// ---- rtl/port_clock_control.sv ----
// Purpose: Run-mode, sleep and deep-sleep clock gating for eight port modules, with fault reporting.
// Assumes: AHB-Lite slave, single word transfers; sleep requests are levels synchronous to ref_clk.
// Notes: Every transfer takes one wait state; faults on gated ports raise sticky status bits.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module port_clock_control
    import port_clock_gate_pkg::*;
#(
    parameter logic [31:0] BASE_ADDRESS = port_clock_gate_pkg::SYSCTL_BASE,
    parameter int PORTS = port_clock_gate_pkg::PORT_COUNT
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic port_req_valid,
    input wire logic [port_clock_gate_pkg::PORT_INDEX_WIDTH-1:0] port_req_index,
    output logic port_req_grant,
    output logic port_req_fault,
    output logic [PORTS-1:0] port_clk,
    output logic [PORTS-1:0] port_clock_on,
    output logic irq
);
    import port_clock_gate_pkg::*;

    logic [31:0] run_mode_port_clock_gate_r;
    logic [31:0] sleep_mode_port_clock_gate_r;
    logic [31:0] deep_sleep_port_clock_gate_r;
    logic [31:0] run_clock_configuration_r;
    logic [31:0] fault_status_r;
    logic [31:0] fault_status_nxt;
    logic [31:0] fault_mask_r;
    power_state_type power_state_r;
    power_state_type power_state_nxt;

    logic [PORTS-1:0] gate_select;
    logic [PORTS-1:0] port_clock_on_r;
    logic auto_clock_gating_select;

    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic pend_valid_r;
    logic pend_write_r;
    logic [11:0] pend_offset_r;
    logic pend_hit_r;

    logic addr_phase;
    logic addr_hit;
    logic [31:0] read_value;
    logic write_now;

    logic guard_grant;
    logic guard_fault;
    logic [PORTS-1:0] guard_fault_event;
    logic irq_r;
    logic write_run;
    logic write_sleep;
    logic write_deep;
    logic write_config;
    logic write_mask;
    logic write_status;

    // Address phase is taken only when the previous data phase has completed
    always_comb
    begin
        addr_phase = hsel & (htrans == HTRANS_NONSEQ) & hready;
        addr_hit = (haddr[31:12] == BASE_ADDRESS[31:12]) & (haddr[1:0] == 2'b00);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pend_valid_r <= 1'b0;
            pend_write_r <= 1'b0;
            pend_offset_r <= 12'h000;
            pend_hit_r <= 1'b0;
        end
        else if (addr_phase)
        begin
            pend_valid_r <= 1'b1;
            pend_write_r <= hwrite;
            pend_offset_r <= haddr[11:0];
            pend_hit_r <= addr_hit;
        end
        else if (pend_valid_r && !hreadyout_r)
        begin
            pend_valid_r <= 1'b0;
        end
    end

    // One wait state lets write data land before any later read samples the registers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            hreadyout_r <= 1'b1;
        else if (addr_phase)
            hreadyout_r <= 1'b0;
        else
            hreadyout_r <= 1'b1;
    end

    assign write_now = pend_valid_r & ~hreadyout_r & pend_write_r & pend_hit_r;

    // One strobe per register; the gate state register has none, so writes to it fall away
    always_comb
    begin
        write_run = write_now & (pend_offset_r == RUN_GATE_OFFSET);
        write_sleep = write_now & (pend_offset_r == SLEEP_GATE_OFFSET);
        write_deep = write_now & (pend_offset_r == DEEP_GATE_OFFSET);
        write_config = write_now & (pend_offset_r == CLOCK_CONFIG_OFFSET);
        write_mask = write_now & (pend_offset_r == FAULT_MASK_OFFSET);
        write_status = write_now & (pend_offset_r == FAULT_STATUS_OFFSET);
    end

    // Other bases, unaligned and unlisted offsets read as zero
    always_comb
    begin
        read_value = 32'h00000000;
        case (pend_offset_r)
            RUN_GATE_OFFSET: read_value = run_mode_port_clock_gate_r & GATE_WRITE_MASK;
            SLEEP_GATE_OFFSET: read_value = sleep_mode_port_clock_gate_r & GATE_WRITE_MASK;
            DEEP_GATE_OFFSET: read_value = deep_sleep_port_clock_gate_r & GATE_WRITE_MASK;
            CLOCK_CONFIG_OFFSET: read_value = run_clock_configuration_r & CONFIG_WRITE_MASK;
            FAULT_STATUS_OFFSET: read_value = fault_status_r & GATE_WRITE_MASK;
            FAULT_MASK_OFFSET: read_value = fault_mask_r & GATE_WRITE_MASK;
            GATE_STATE_OFFSET: read_value = {{(32-PORTS){1'b0}}, port_clock_on_r};
            default: read_value = 32'h00000000;
        endcase
        if (!pend_hit_r)
            read_value = 32'h00000000;
    end

    // Read data holds until the next read completes
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            hrdata_r <= 32'h00000000;
        else if (pend_valid_r && !hreadyout_r && !pend_write_r)
            hrdata_r <= read_value;
    end

    // Run-mode gating register: only the eight port bits hold state
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            run_mode_port_clock_gate_r <= GATE_RESET;
        else if (write_run)
            run_mode_port_clock_gate_r <= hwdata & GATE_WRITE_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            sleep_mode_port_clock_gate_r <= GATE_RESET;
        else if (write_sleep)
            sleep_mode_port_clock_gate_r <= hwdata & GATE_WRITE_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            deep_sleep_port_clock_gate_r <= GATE_RESET;
        else if (write_deep)
            deep_sleep_port_clock_gate_r <= hwdata & GATE_WRITE_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            run_clock_configuration_r <= CONFIG_RESET;
        else if (write_config)
            run_clock_configuration_r <= hwdata & CONFIG_WRITE_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fault_mask_r <= FAULT_RESET;
        else if (write_mask)
            fault_mask_r <= hwdata & GATE_WRITE_MASK;
    end

    assign auto_clock_gating_select = run_clock_configuration_r[AUTO_GATE_BIT];

    // Power state follows the sleep request levels; deep sleep wins over sleep
    always_comb
    begin
        case (power_state_r)
            PWR_RUN:
            begin
                if (deep_sleep_req)
                    power_state_nxt = PWR_DEEP;
                else if (sleep_req)
                    power_state_nxt = PWR_SLEEP;
                else
                    power_state_nxt = PWR_RUN;
            end
            PWR_SLEEP:
            begin
                if (deep_sleep_req)
                    power_state_nxt = PWR_DEEP;
                else if (sleep_req)
                    power_state_nxt = PWR_SLEEP;
                else
                    power_state_nxt = PWR_RUN;
            end
            PWR_DEEP:
            begin
                if (deep_sleep_req)
                    power_state_nxt = PWR_DEEP;
                else if (sleep_req)
                    power_state_nxt = PWR_SLEEP;
                else
                    power_state_nxt = PWR_RUN;
            end
            default: power_state_nxt = PWR_RUN;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            power_state_r <= PWR_RUN;
        else
            power_state_r <= power_state_nxt;
    end

    // Without auto gating the run-mode setting stays in force through sleep
    always_comb
    begin
        gate_select = run_mode_port_clock_gate_r[PORTS-1:0];
        case (power_state_r)
            PWR_RUN: gate_select = run_mode_port_clock_gate_r[PORTS-1:0];
            PWR_SLEEP:
            begin
                if (auto_clock_gating_select)
                    gate_select = sleep_mode_port_clock_gate_r[PORTS-1:0];
            end
            PWR_DEEP:
            begin
                if (auto_clock_gating_select)
                    gate_select = deep_sleep_port_clock_gate_r[PORTS-1:0];
            end
            default: gate_select = run_mode_port_clock_gate_r[PORTS-1:0];
        endcase
    end

    // Registered so the guard and the gates judge by the same enable for a whole cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            port_clock_on_r <= '0;
        else
            port_clock_on_r <= gate_select;
    end

    // One gate per port; a cleared bit leaves the port with no edges at all
    genvar g;
    generate
        for (g = 0; g < PORTS; g++)
        begin : gen_port_gate
            glitch_free_clock_gate u_gate
            (
                .clk_in(ref_clk),
                .reset(reset),
                .enable(port_clock_on_r[g]),
                .clk_out(port_clk[g])
            );
        end
    endgenerate

    // An access is judged against the enable the gate is about to retime, not the raw register
    port_access_guard #(
        .PORTS(PORTS),
        .INDEX_WIDTH(PORT_INDEX_WIDTH)
    ) u_guard
    (
        .clk(ref_clk),
        .reset(reset),
        .req_valid(port_req_valid),
        .req_index(port_req_index),
        .clock_on(port_clock_on_r),
        .grant_r(guard_grant),
        .fault_r(guard_fault),
        .fault_event_r(guard_fault_event)
    );

    // A fault arriving with its write-one-to-clear keeps the bit set
    always_comb
    begin
        fault_status_nxt = fault_status_r;
        if (write_status)
            fault_status_nxt = fault_status_nxt & ~(hwdata & GATE_WRITE_MASK);
        fault_status_nxt = fault_status_nxt | {{(32-PORTS){1'b0}}, guard_fault_event};
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fault_status_r <= FAULT_RESET;
        else
            fault_status_r <= fault_status_nxt;
    end

    // Registered so irq leaves a flop; it trails the status by one cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            irq_r <= 1'b0;
        else
            irq_r <= |(fault_status_r & fault_mask_r);
    end

    assign hreadyout = hreadyout_r;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_r;
    assign port_req_grant = guard_grant;
    assign port_req_fault = guard_fault;
    assign port_clock_on = port_clock_on_r;
    assign irq = irq_r;
endmodule : port_clock_control

// ---- rtl/port_clock_gate_pkg.sv ----
// Purpose: Shared constants and types for the port clock gating block.
// Assumes: 32-bit AHB-Lite register access, byte addresses relative to the system control base.
// Notes: Offsets are byte offsets; every register is one aligned word.
package port_clock_gate_pkg;
    localparam int PORT_COUNT = 8;
    localparam int PORT_INDEX_WIDTH = 3;
    localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
    localparam logic [11:0] RUN_GATE_OFFSET = 12'h108;
    localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h118;
    localparam logic [11:0] DEEP_GATE_OFFSET = 12'h128;
    localparam logic [11:0] CLOCK_CONFIG_OFFSET = 12'h1F0;
    localparam logic [11:0] FAULT_STATUS_OFFSET = 12'h1F4;
    localparam logic [11:0] FAULT_MASK_OFFSET = 12'h1F8;
    localparam logic [11:0] GATE_STATE_OFFSET = 12'h1FC;
    localparam logic [31:0] GATE_RESET = 32'h00000000;
    localparam logic [31:0] CONFIG_RESET = 32'h00000000;
    localparam logic [31:0] FAULT_RESET = 32'h00000000;
    localparam logic [31:0] GATE_WRITE_MASK = 32'h000000FF;
    localparam logic [31:0] CONFIG_WRITE_MASK = 32'h00000001;
    localparam int AUTO_GATE_BIT = 0;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0]
    {
        PWR_RUN = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_DEEP = 3'b100
    } power_state_type;
endpackage : port_clock_gate_pkg
